// ### hw/bwc_bor_decode.sv
module bwc_bor_decode
	import bwc_pkg::*;
(
	bwc_ctl_if.bor ctl
);

	bwc_policy_e policy;
	bwc_power_e  power;
	logic [1:0]  trip;

	function automatic logic [11:0] trip_to_mv(input logic [1:0] code);
		unique case (code)
			2'b11: trip_to_mv = BWC_TRIP_MV_11;
			2'b10: trip_to_mv = BWC_TRIP_MV_10;
			2'b01: trip_to_mv = BWC_TRIP_MV_01;
			2'b00: trip_to_mv = BWC_TRIP_MV_00;
		endcase
	endfunction : trip_to_mv

	assign policy = bwc_policy_e'(ctl.cfg_byte[BWC_CFG_POL_LSB +: 2]);
	assign power  = bwc_power_e'(ctl.cfg_byte[BWC_CFG_PWR_LSB +: 2]);
	assign trip   = ctl.cfg_byte[BWC_CFG_TRIP_LSB +: 2];

	// Zero-power monitor replaces the level-controlled one
	assign ctl.zero_power_monitor  = (power == BWC_PWR_ZERO);
	assign ctl.monitor_power_level = power;
	assign ctl.trip_mv             = trip_to_mv(trip);

	always_comb begin
		unique case (policy)
			BWC_POL_HARD:  ctl.undervoltage_reset_active = 1'b1;
			BWC_POL_AWAKE: ctl.undervoltage_reset_active = ~ctl.sleep;
			BWC_POL_SOFT:  ctl.undervoltage_reset_active =
				ctl.soft_undervoltage_enable;
			BWC_POL_OFF:   ctl.undervoltage_reset_active = 1'b0;
		endcase
	end

	// Timer bit is read on its own, never mixed with the policy
	assign ctl.powerup_timer_active = ~ctl.cfg_byte[BWC_CFG_PUT_BIT];

endmodule : bwc_bor_decode

// ### hw/bwc_ctl_if.sv
interface bwc_ctl_if;
	logic [7:0] cfg_byte;
	logic       soft_undervoltage_enable;
	logic       sleep;
	logic [1:0] watchdog_config_enable;
	logic       regulator_enable_option;
	logic       retention_option_n;
	logic [7:0] wdt_pwr;
	logic       undervoltage_reset_active;
	logic [1:0] monitor_power_level;
	logic       zero_power_monitor;
	logic [11:0] trip_mv;
	logic       powerup_timer_active;
	logic       watchdog_run;
	logic       sleep_disable_avail;
	logic       regulator_lowpower;
	logic       ultra_lowpower;
	logic       sink_active;

	modport top (
		output cfg_byte, soft_undervoltage_enable, sleep, watchdog_config_enable,
		output regulator_enable_option, retention_option_n, wdt_pwr,
		input  undervoltage_reset_active, monitor_power_level, zero_power_monitor,
		input  trip_mv, powerup_timer_active, watchdog_run, sleep_disable_avail,
		input  regulator_lowpower, ultra_lowpower, sink_active
	);
	modport bor (
		input  cfg_byte, soft_undervoltage_enable, sleep,
		output undervoltage_reset_active, monitor_power_level, zero_power_monitor,
		output trip_mv, powerup_timer_active
	);
	modport wdt (
		input  sleep, watchdog_config_enable, regulator_enable_option,
		input  retention_option_n, wdt_pwr,
		output watchdog_run, sleep_disable_avail, regulator_lowpower,
		output ultra_lowpower, sink_active
	);
endinterface : bwc_ctl_if

// ### hw/bwc_pkg.sv
package bwc_pkg;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] BWC_ADDR_CFG_LOW   = 8'h00;
	localparam logic [7:0] BWC_ADDR_WDT_PWR   = 8'h04;
	localparam logic [7:0] BWC_ADDR_RST_CAUSE = 8'h08;
	localparam logic [7:0] BWC_ADDR_STATUS    = 8'h0C;

	// ------------------------------------------------------------
	// Configuration byte fields
	// ------------------------------------------------------------
	localparam int BWC_CFG_PUT_BIT  = 0;
	localparam int BWC_CFG_POL_LSB  = 1;
	localparam int BWC_CFG_TRIP_LSB = 3;
	localparam int BWC_CFG_PWR_LSB  = 5;
	localparam logic [7:0] BWC_CFG_MASK  = 8'h7F;
	localparam logic [7:0] BWC_CFG_RESET = 8'h7F;

	// ------------------------------------------------------------
	// Watchdog and power control fields
	// ------------------------------------------------------------
	localparam int BWC_WDT_SWDT_BIT   = 0;
	localparam int BWC_WDT_SINK_BIT   = 1;
	localparam int BWC_WDT_WAKE_BIT   = 2;
	localparam int BWC_WDT_SRET_BIT   = 4;
	localparam int BWC_WDT_LEVEL_BIT  = 5;
	localparam int BWC_WDT_REGLP_BIT  = 7;
	localparam logic [7:0] BWC_WDT_WR_MASK = 8'h87;
	localparam logic [7:0] BWC_WDT_RESET   = 8'h00;

	// ------------------------------------------------------------
	// Reset cause control fields
	// ------------------------------------------------------------
	localparam int   BWC_RST_SBOR_BIT   = 6;
	localparam logic BWC_RST_SBOR_RESET = 1'b1;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		BWC_POL_OFF   = 2'b00,
		BWC_POL_SOFT  = 2'b01,
		BWC_POL_AWAKE = 2'b10,
		BWC_POL_HARD  = 2'b11
	} bwc_policy_e;

	typedef enum logic [1:0] {
		BWC_PWR_LOW    = 2'b00,
		BWC_PWR_MEDIUM = 2'b01,
		BWC_PWR_HIGH   = 2'b10,
		BWC_PWR_ZERO   = 2'b11
	} bwc_power_e;

	localparam logic [11:0] BWC_TRIP_MV_11 = 12'h708;
	localparam logic [11:0] BWC_TRIP_MV_10 = 12'h7D0;
	localparam logic [11:0] BWC_TRIP_MV_01 = 12'hA8C;
	localparam logic [11:0] BWC_TRIP_MV_00 = 12'hBB8;
	localparam logic [1:0]  BWC_WDT_CFG_OFF = 2'b00;

endpackage : bwc_pkg

// ### hw/bwc_top.sv
module bwc_top
	import bwc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	// APB slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic             pready_out,
	output logic [31:0]      prdata_out,
	output logic             pslverr_out,
	// Device pins and fuse levels
	input  wire logic        sleep_in,
	input  wire logic [1:0]  watchdog_config_enable_in,
	input  wire logic        regulator_enable_option_in,
	input  wire logic        retention_option_n_in,
	input  wire logic        lowpower_wake_level_in,
	// Undervoltage monitor controls
	output logic             undervoltage_reset_active_out,
	output logic [1:0]       monitor_power_level_out,
	output logic             zero_power_monitor_out,
	output logic [1:0]       trip_voltage_select_out,
	output logic [11:0]      trip_voltage_mv_out,
	output logic             powerup_timer_active_out,
	// Watchdog and regulator controls
	output logic             watchdog_run_out,
	output logic             regulator_lowpower_out,
	output logic             ultra_lowpower_out,
	output logic             lowpower_wake_enable_out,
	output logic             lowpower_wake_sink_out
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	localparam int SYNC_W = 6;

	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic              sleep_s;
	logic [1:0]        wdt_cfg_s;
	logic              reg_opt_s;
	logic              ret_n_s;
	logic              wake_level_s;

	// First stage feeds only the second stage
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			sync1_q <= '0;
		end else begin
			sync1_q <= {lowpower_wake_level_in, retention_option_n_in,
				regulator_enable_option_in, watchdog_config_enable_in, sleep_in};
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			sync2_q <= '0;
		end else begin
			sync2_q <= sync1_q;
		end
	end

	assign sleep_s      = sync2_q[0];
	assign wdt_cfg_s    = sync2_q[2:1];
	assign reg_opt_s    = sync2_q[3];
	assign ret_n_s      = sync2_q[4];
	assign wake_level_s = sync2_q[5];

	// ------------------------------------------------------------
	// APB handshake
	// ------------------------------------------------------------
	logic        access;
	logic        wr_en;
	logic        rd_en;
	logic        mapped;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] rdata_d;

	// One wait state keeps pready and prdata straight from flops
	assign access = psel_in & penable_in & ~pready_q;
	assign wr_en  = psel_in & penable_in & pready_q & pwrite_in & mapped;
	assign rd_en  = access & ~pwrite_in;

	assign mapped = (paddr_in == BWC_ADDR_CFG_LOW) | (paddr_in == BWC_ADDR_WDT_PWR)
		| (paddr_in == BWC_ADDR_RST_CAUSE) | (paddr_in == BWC_ADDR_STATUS);

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= access;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= access & ~mapped;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			prdata_q <= '0;
		end else if (rd_en) begin
			prdata_q <= rdata_d;
		end else if (access) begin
			prdata_q <= '0;
		end
	end

	assign pready_out  = pready_q;
	assign pslverr_out = pslverr_q;
	assign prdata_out  = prdata_q;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] cfg_q;
	logic [7:0] wdt_q;
	logic       soft_uv_en_q;
	logic       sret_avail;
	logic       wr_cfg;
	logic       wr_wdt;
	logic       wr_rst;

	// Per-register strobes, live only in the ready cycle
	assign wr_cfg = wr_en & (paddr_in == BWC_ADDR_CFG_LOW);
	assign wr_wdt = wr_en & (paddr_in == BWC_ADDR_WDT_PWR);
	assign wr_rst = wr_en & (paddr_in == BWC_ADDR_RST_CAUSE);

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			cfg_q <= BWC_CFG_RESET;
		end else if (wr_cfg) begin
			cfg_q <= pwdata_in[7:0] & BWC_CFG_MASK;
		end
	end

	// Sleep-disable bit cannot be set while unavailable, and drops if it goes
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			wdt_q <= BWC_WDT_RESET;
		end else begin
			if (wr_wdt) begin
				wdt_q <= pwdata_in[7:0] & BWC_WDT_WR_MASK;
				wdt_q[BWC_WDT_SRET_BIT] <= pwdata_in[BWC_WDT_SRET_BIT]
					& sret_avail;
			end else if (!sret_avail) begin
				wdt_q[BWC_WDT_SRET_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			soft_uv_en_q <= BWC_RST_SBOR_RESET;
		end else if (wr_rst) begin
			soft_uv_en_q <= pwdata_in[BWC_RST_SBOR_BIT];
		end
	end

	// ------------------------------------------------------------
	// Decode blocks
	// ------------------------------------------------------------
	bwc_ctl_if ctl ();

	assign ctl.cfg_byte                 = cfg_q;
	assign ctl.soft_undervoltage_enable = soft_uv_en_q;
	assign ctl.sleep                    = sleep_s;
	assign ctl.watchdog_config_enable   = wdt_cfg_s;
	assign ctl.regulator_enable_option  = reg_opt_s;
	assign ctl.retention_option_n       = ret_n_s;
	assign ctl.wdt_pwr                  = wdt_q;
	assign sret_avail                   = ctl.sleep_disable_avail;

	bwc_bor_decode u_bor (
		.ctl (ctl.bor)
	);

	bwc_wdt_ctrl u_wdt (
		.ctl (ctl.wdt)
	);

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	logic [7:0] wdt_view;
	logic [7:0] status_view;

	always_comb begin
		wdt_view = wdt_q;
		wdt_view[BWC_WDT_LEVEL_BIT] = wake_level_s & wdt_q[BWC_WDT_WAKE_BIT];
		wdt_view[BWC_WDT_SINK_BIT]  = wdt_q[BWC_WDT_SINK_BIT];
	end

	assign status_view = {1'b0, ctl.ultra_lowpower, ctl.regulator_lowpower,
		ctl.watchdog_run, ctl.powerup_timer_active, sleep_s,
		ctl.zero_power_monitor, ctl.undervoltage_reset_active};

	always_comb begin
		rdata_d = '0;
		unique case (paddr_in)
			BWC_ADDR_CFG_LOW:   rdata_d[7:0] = cfg_q & BWC_CFG_MASK;
			BWC_ADDR_WDT_PWR:   rdata_d[7:0] = wdt_view;
			BWC_ADDR_RST_CAUSE: rdata_d[BWC_RST_SBOR_BIT] = soft_uv_en_q;
			BWC_ADDR_STATUS:    rdata_d[7:0] = status_view;
			default:            rdata_d = '0;
		endcase
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			undervoltage_reset_active_out <= 1'b0;
		end else begin
			undervoltage_reset_active_out <= ctl.undervoltage_reset_active;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			monitor_power_level_out <= '0;
			zero_power_monitor_out  <= 1'b0;
		end else begin
			monitor_power_level_out <= ctl.monitor_power_level;
			zero_power_monitor_out  <= ctl.zero_power_monitor;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			trip_voltage_select_out <= '0;
			trip_voltage_mv_out     <= '0;
		end else begin
			trip_voltage_select_out <= cfg_q[BWC_CFG_TRIP_LSB +: 2];
			trip_voltage_mv_out     <= ctl.trip_mv;
		end
	end

	// Timer output has its own flop, untouched by the policy decode
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			powerup_timer_active_out <= 1'b0;
		end else begin
			powerup_timer_active_out <= ctl.powerup_timer_active;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			watchdog_run_out <= 1'b0;
		end else begin
			watchdog_run_out <= ctl.watchdog_run;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			regulator_lowpower_out <= 1'b0;
			ultra_lowpower_out     <= 1'b0;
		end else begin
			regulator_lowpower_out <= ctl.regulator_lowpower;
			ultra_lowpower_out     <= ctl.ultra_lowpower;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			lowpower_wake_enable_out <= 1'b0;
			lowpower_wake_sink_out   <= 1'b0;
		end else begin
			lowpower_wake_enable_out <= wdt_q[BWC_WDT_WAKE_BIT];
			lowpower_wake_sink_out   <= ctl.sink_active;
		end
	end

endmodule : bwc_top

// ### hw/bwc_wdt_ctrl.sv
module bwc_wdt_ctrl
	import bwc_pkg::*;
(
	bwc_ctl_if.wdt ctl
);

	logic cfg_wdt_on;

	assign cfg_wdt_on = (ctl.watchdog_config_enable != BWC_WDT_CFG_OFF);

	// Software bit only counts while the fuses leave the watchdog off
	assign ctl.watchdog_run = cfg_wdt_on | ctl.wdt_pwr[BWC_WDT_SWDT_BIT];

	assign ctl.sleep_disable_avail = ctl.regulator_enable_option
		& ~ctl.retention_option_n;

	assign ctl.ultra_lowpower = ctl.sleep & ctl.sleep_disable_avail
		& ctl.wdt_pwr[BWC_WDT_SRET_BIT];

	assign ctl.regulator_lowpower = ctl.sleep & ~ctl.ultra_lowpower
		& ctl.wdt_pwr[BWC_WDT_REGLP_BIT];

	assign ctl.sink_active = ctl.wdt_pwr[BWC_WDT_WAKE_BIT]
		& ctl.wdt_pwr[BWC_WDT_SINK_BIT];

endmodule : bwc_wdt_ctrl

// ### testbench/brownout_watchdog_config_test.sv
module brownout_watchdog_config_test
	import bwc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        clk_in = 1'b0, reset_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0;
	logic        pwrite_in = 1'b0, sleep_in = 1'b0, regulator_enable_option_in = 1'b0;
	logic        retention_option_n_in = 1'b1, lowpower_wake_level_in = 1'b0;
	logic [1:0]  watchdog_config_enable_in = 2'b00;
	logic [7:0]  paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h00000000;
	logic        pready_out, pslverr_out, undervoltage_reset_active_out;
	logic        zero_power_monitor_out, powerup_timer_active_out, watchdog_run_out;
	logic        regulator_lowpower_out, ultra_lowpower_out, lowpower_wake_enable_out;
	logic        lowpower_wake_sink_out, rerr, ua, av;
	logic [31:0] prdata_out, rdata;
	logic [1:0]  monitor_power_level_out, trip_voltage_select_out;
	logic [11:0] trip_voltage_mv_out;
	logic [11:0] mv [4] = '{12'hBB8, 12'hA8C, 12'h7D0, 12'h708};
	logic [7:0]  cf;
	int          fail_count = 0, cmp_count = 0;

	bwc_top bwc_top_i (.*);

	always #12.5 clk_in = ~clk_in;

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 50);
		if (n >= 50) fail_count++;
		rdata = prdata_out;
		rerr = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h00000000);
		chk("prdata", e, rdata);
		chk("pslverr", ee, rerr);
	endtask : rd

	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk_in);
		reset_in <= 1'b0;
		rd(BWC_ADDR_CFG_LOW, 32'h0000007F, 1'b0);
		rd(BWC_ADDR_WDT_PWR, 32'h00000000, 1'b0);
		rd(BWC_ADDR_RST_CAUSE, 32'h00000040, 1'b0);
		$display("test reset done");
		for (int c = 0; c < 4; c++) begin
			for (int s = 0; s < 4; s++) begin
				sleep_in <= s[1];
				wr(BWC_ADDR_RST_CAUSE, {25'h0, s[0], 6'h00});
				cf = {1'b1, c[1:0], c[1:0], c[1:0], s[0]};
				wr(BWC_ADDR_CFG_LOW, {24'h0, cf});
				repeat (5) @(posedge clk_in);
				ua = (c == 3) || (c == 2 && !s[1]) || (c == 1 && s[0]);
				chk("uv_active", ua, undervoltage_reset_active_out);
				chk("pwr_level", 32'(c), monitor_power_level_out);
				chk("zero_power", c == 3, zero_power_monitor_out);
				chk("trip_sel", 32'(c), trip_voltage_select_out);
				chk("trip_mv", mv[c], trip_voltage_mv_out);
				chk("pu_timer", !s[0], powerup_timer_active_out);
				rd(BWC_ADDR_CFG_LOW, {24'h0, 1'b0, cf[6:0]}, 1'b0);
			end
		end
		$display("test config done");
		for (int i = 0; i < 8; i++) begin
			watchdog_config_enable_in <= i[2:1];
			wr(BWC_ADDR_WDT_PWR, {31'h0, i[0]});
			repeat (5) @(posedge clk_in);
			chk("wdt_run", i[2:1] != 2'b00 || i[0], watchdog_run_out);
		end
		$display("test watchdog done");
		sleep_in <= 1'b1;
		lowpower_wake_level_in <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			regulator_enable_option_in <= i[0];
			retention_option_n_in <= i[1];
			wr(BWC_ADDR_WDT_PWR, 32'h00000097);
			repeat (5) @(posedge clk_in);
			av = (i == 1);
			chk("ultra_lp", av, ultra_lowpower_out);
			chk("reg_lp", !av, regulator_lowpower_out);
			chk("wake_sink", 1'b1, lowpower_wake_sink_out);
			chk("wake_en", 1'b1, lowpower_wake_enable_out);
			rd(BWC_ADDR_WDT_PWR, {24'h0, 3'h5, av, 4'h7}, 1'b0);
		end
		wr(BWC_ADDR_WDT_PWR, 32'h00000007);
		repeat (5) @(posedge clk_in);
		chk("reg_lp", 1'b0, regulator_lowpower_out);
		sleep_in <= 1'b0;
		wr(BWC_ADDR_WDT_PWR, 32'h00000003);
		repeat (5) @(posedge clk_in);
		chk("wake_en", 1'b0, lowpower_wake_enable_out);
		chk("wake_sink", 1'b0, lowpower_wake_sink_out);
		rd(BWC_ADDR_WDT_PWR, 32'h00000003, 1'b0);
		$display("test regulator done");
		wr(8'h10, 32'hFFFFFFFF);
		rd(8'h10, 32'h00000000, 1'b1);
		wr(BWC_ADDR_RST_CAUSE, 32'hFFFFFFBF);
		rd(BWC_ADDR_RST_CAUSE, 32'h00000000, 1'b0);
		rd(BWC_ADDR_STATUS, 32'h00000013, 1'b0);
		$display("test bus done");
		test_done();
	end

	// Generous bound: the full run needs under two thousand cycles
	initial begin
		repeat (6000) @(posedge clk_in);
		fail_count++;
		test_done();
	end
endmodule : brownout_watchdog_config_test

bind bwc_top bwc_top_assertions bwc_top_assertions_i (.*);

// ### testbench/bwc_top_assertions.sv
module bwc_top_assertions
	import bwc_pkg::*;
(
	// Clock, reset and bus
	input logic        clk_in,
	input logic        reset_in,
	input logic        psel_in,
	input logic        penable_in,
	input logic        pwrite_in,
	input logic [7:0]  paddr_in,
	input logic        pready_out,
	input logic [31:0] prdata_out,
	input logic        pslverr_out,
	// Pins and controls
	input logic        sleep_in,
	input logic [1:0]  watchdog_config_enable_in,
	input logic        regulator_enable_option_in,
	input logic [1:0]  monitor_power_level_out,
	input logic        zero_power_monitor_out,
	input logic [1:0]  trip_voltage_select_out,
	input logic [11:0] trip_voltage_mv_out,
	input logic        watchdog_run_out,
	input logic        regulator_lowpower_out,
	input logic        ultra_lowpower_out,
	input logic        lowpower_wake_enable_out,
	input logic        lowpower_wake_sink_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	localparam logic [11:0] MV [4] = '{12'hBB8, 12'hA8C, 12'h7D0, 12'h708};
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (reset_in);
	sequence s_setup;
		psel_in && !penable_in;
	endsequence
	sequence s_access;
		psel_in && penable_in;
	endsequence
	chk_ready_wait: assert property (s_setup ##1 s_access |-> !pready_out ##1 pready_out)
		else $error("ready not one wait state");
	chk_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("ready longer than a cycle");
	chk_err_unmapped: assert property (pready_out && paddr_in[1:0] == 2'b00
		|-> pslverr_out == (paddr_in > 8'h0C)) else $error("error flag wrong");
	chk_read_zeros: assert property (pready_out && !pwrite_in |->
		prdata_out[31:8] == 24'h000000 && !(paddr_in == BWC_ADDR_CFG_LOW && prdata_out[7]))
		else $error("unused read bits set");
	chk_zero_power: assert property (zero_power_monitor_out ==
		(monitor_power_level_out == 2'b11)) else $error("zero power decode");
	chk_trip_table: assert property (!$past(reset_in) |->
		trip_voltage_mv_out == MV[trip_voltage_select_out]) else $error("trip table");
	chk_wdt_forced: assert property ((watchdog_config_enable_in != 2'b00) [*5]
		|-> watchdog_run_out) else $error("watchdog not forced");
	chk_awake_normal: assert property (!sleep_in [*5]
		|-> !regulator_lowpower_out && !ultra_lowpower_out) else $error("low power awake");
	chk_mode_excl: assert property (!(regulator_lowpower_out && ultra_lowpower_out))
		else $error("both sleep modes");
	chk_sret_option: assert property (!regulator_enable_option_in [*5]
		|-> !ultra_lowpower_out) else $error("ultra low power without option");
	chk_sink_gate: assert property (lowpower_wake_sink_out |-> lowpower_wake_enable_out)
		else $error("sink without wake enable");
endmodule : bwc_top_assertions
